// ===== pnp_config_register_bank.sv
// Behaviour
// - writing 1 to bit 0 of the config control register soft-resets the configuration.
// - vendor registers 21h-24h and each device's F0h survive a soft reset.
// - card select number 06h and device number 07h are read/write, 00h after hard reset.
// - keyboard data base low resets to 60h; its bit 2 always reads 0.
// - keyboard command base low resets to 64h; its bit 2 always reads 1.
// - keyboard irq select resets 01h; irq type resets 02h, only bits 1:0 writable.
// - keyboard activate resets to the strap bit, and power enable gates it.
// - mouse irq pin is never asserted while the mouse device is inactive.
// - mouse activation never blocks host commands for the pointing device.
// - mouse irq select resets 0Ch; irq type resets 02h, only bits 1:0 writable.
// - dma select registers 74h and 75h read 04h for all three devices.
// - clock power control keeps running whatever the clock activate bit says.
// - clock base low resets to 70h; its bit 0 always reads 0.
// - clock irq select resets 08h; irq type resets 00h, only bit 1 writable.
// - irq type bit 0 picks edge or level, bit 1 low open-drain or high push-pull.
//
// Implementation choice: the Wishbone register port.
module pnp_config_register_bank
  import pnp_cfg_pkg::*;
#(
  parameter logic [7:0] CHIP_ID  = 8'hA5, // arbitrary value
  parameter logic [7:0] CHIP_REV = 8'h01  // arbitrary value
) (
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   nrst_in,
  // wishbone slave
  input  wire wb_req_s                wb_req_in,
  output wb_rsp_s                     wb_rsp_out,
  // straps and power management enables
  input  wire logic                   strap_config_bit_in,
  input  wire logic                   kbd_power_enable_in,
  input  wire logic                   clock_power_enable_in,
  // interrupt requests from the controller, index 0 keyboard, 1 mouse
  input  wire logic [1:0]             irq_req_in,
  output logic      [1:0]             irq_pin_out,
  output logic      [1:0]             irq_pin_oe_out,
  // pointing device command path
  input  wire logic                   aux_cmd_req_in,
  output logic                        aux_cmd_accept_out,
  // decoded device settings
  output ld_cfg_s   [NUM_LD-1:0]      ld_cfg_out,
  output logic                        clock_power_control_out
);

  // whole state of the bank
  typedef struct packed {
    ld_regs_s [NUM_LD-1:0] ld;
    logic [7:0]            card_select_number;
    logic [7:0]            ldn;
    logic [7:0]            wake;
    logic [7:0]            rd_port;
    logic [3:0][7:0]       chip_cfg;
    logic                  init_done;
    logic                  ack;
    logic [7:0]            rdata;
  } bank_state_s;

  bank_state_s s_q;
  bank_state_s s_d;

  logic [7:0]  idx;
  logic        req;
  logic        commit_wr;
  logic        soft_rst;
  logic        ldn_ok;
  logic [1:0]  ld_sel;

  // soft/hard default of one logical device, vendor byte kept by caller
  function automatic ld_regs_s ld_default(input int ld, input logic strap, input logic [7:0] vend);
    ld_regs_s r;
    r           = '0;
    r.act       = (ld == int'(LD_MOUSE)) ? BYTE_ZERO : {7'h00, strap};
    r.range_chk = BYTE_ZERO;
    r.base_hi   = BYTE_ZERO;
    r.base_lo   = BASE_LO_RST[ld];
    r.cmd_hi    = BYTE_ZERO;
    r.cmd_lo    = (ld == int'(LD_KBD)) ? CMD_LO_RST : BYTE_ZERO;
    r.isel      = ISEL_RST[ld];
    r.itype     = ITYPE_RST[ld];
    r.vendor    = vend;
    return r;
  endfunction : ld_default

  // merge write data into writable bits only
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] wm);
    return (wd & wm) | (old & ~wm);
  endfunction : merge

  // register write into one logical device, absent registers ignore it
  function automatic ld_regs_s ld_write(input ld_regs_s r, input int ld, input logic [7:0] i,
                                        input logic [7:0] wd);
    ld_regs_s n;
    logic     kbd;
    logic     mou;
    n   = r;
    kbd = (ld == int'(LD_KBD));
    mou = (ld == int'(LD_MOUSE));
    case (i)
      IDX_ACT:     n.act = merge(r.act, wd, ACT_WMASK);
      IDX_RANGE:   if (!mou) n.range_chk = merge(r.range_chk, wd, RANGE_WMASK);
      IDX_BASE_HI: if (!mou) n.base_hi = wd;
      IDX_BASE_LO: if (!mou) n.base_lo = merge(r.base_lo, wd, BASE_LO_WMASK[ld]);
      IDX_CMD_HI:  if (kbd) n.cmd_hi = wd;
      IDX_CMD_LO:  if (kbd) n.cmd_lo = merge(r.cmd_lo, wd, CMD_LO_WMASK);
      IDX_ISEL:    n.isel = wd;
      IDX_ITYPE:   n.itype = merge(r.itype, wd, ITYPE_WMASK[ld]);
      IDX_VENDOR:  if (kbd) n.vendor = wd;
      default:     n = r;
    endcase
    return n;
  endfunction : ld_write

  // read of one logical device register
  function automatic logic [7:0] ld_read(input ld_regs_s r, input int ld, input logic [7:0] i);
    logic       kbd;
    logic       mou;
    logic [7:0] v;
    kbd = (ld == int'(LD_KBD));
    mou = (ld == int'(LD_MOUSE));
    v   = BYTE_ZERO;
    case (i)
      IDX_ACT:     v = r.act;
      IDX_RANGE:   v = mou ? BYTE_ZERO : r.range_chk;
      IDX_BASE_HI: v = mou ? BYTE_ZERO : r.base_hi;
      IDX_BASE_LO: v = mou ? BYTE_ZERO : r.base_lo;
      IDX_CMD_HI:  v = kbd ? r.cmd_hi : BYTE_ZERO;
      IDX_CMD_LO:  v = kbd ? r.cmd_lo : BYTE_ZERO;
      IDX_ISEL:    v = r.isel;
      IDX_ITYPE:   v = r.itype;
      IDX_DMA0,
      IDX_DMA1:    v = DMA_NONE;
      IDX_VENDOR:  v = kbd ? r.vendor : BYTE_ZERO;
      default:     v = BYTE_ZERO;
    endcase
    return v;
  endfunction : ld_read

  // request decode
  assign idx       = wb_req_in.adr[IDX_LSB +: 8];
  assign req       = wb_req_in.cyc & wb_req_in.stb;
  assign commit_wr = req & wb_req_in.we & s_q.ack & wb_req_in.sel[SEL_LOW];
  assign soft_rst  = commit_wr & (idx == IDX_CTRL) & wb_req_in.dat[CTRL_SOFT_RST_BIT];
  assign ldn_ok    = (s_q.ldn < LD_COUNT);
  assign ld_sel    = s_q.ldn[1:0];

  // next state
  always_comb begin
    s_d     = s_q;
    s_d.ack = req & ~s_q.ack;
    // first cycle after hard reset release catches the strap
    if (!s_q.init_done) begin
      s_d.init_done = 1'b1;
      for (int k = 0; k < NUM_LD; k++) begin
        s_d.ld[k] = ld_default(k, strap_config_bit_in, VENDOR_RST);
      end
    end
    // read data is captured when the request is first seen
    if (req && !s_q.ack) begin
      case (idx)
        IDX_CSN:      s_d.rdata = s_q.card_select_number;
        IDX_LDN:      s_d.rdata = s_q.ldn;
        IDX_CHIP_ID:  s_d.rdata = CHIP_ID;
        IDX_CFG_ONE,
        IDX_CFG_TWO,
        IDX_CS_INDEX,
        IDX_CS_DATA:  s_d.rdata = s_q.chip_cfg[idx[1:0] - 2'd1];
        IDX_CHIP_REV: s_d.rdata = CHIP_REV;
        default: begin
          if (idx >= IDX_ACT && ldn_ok) begin
            s_d.rdata = ld_read(s_q.ld[ld_sel], int'(ld_sel), idx);
          end else begin
            s_d.rdata = BYTE_ZERO;
          end
        end
      endcase
    end
    // writes take effect at the acknowledging edge
    if (commit_wr) begin
      case (idx)
        IDX_RD_PORT:  s_d.rd_port = wb_req_in.dat[7:0];
        IDX_WAKE:     s_d.wake    = wb_req_in.dat[7:0];
        IDX_CSN:      s_d.card_select_number     = wb_req_in.dat[7:0];
        IDX_LDN:      s_d.ldn     = wb_req_in.dat[7:0];
        IDX_CFG_ONE,
        IDX_CFG_TWO,
        IDX_CS_INDEX,
        IDX_CS_DATA:  s_d.chip_cfg[idx[1:0] - 2'd1] = wb_req_in.dat[7:0];
        default: begin
          if (idx >= IDX_ACT && ldn_ok) begin
            s_d.ld[ld_sel] = ld_write(s_q.ld[ld_sel], int'(ld_sel), idx, wb_req_in.dat[7:0]);
          end
        end
      endcase
    end
    // soft reset restores device defaults but keeps vendor bytes
    if (soft_rst) begin
      for (int k = 0; k < NUM_LD; k++) begin
        s_d.ld[k] = ld_default(k, strap_config_bit_in, s_q.ld[k].vendor);
      end
    end
  end

  // state register, hard reset to constants
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // bus answer
  assign wb_rsp_out.ack = s_q.ack;
  assign wb_rsp_out.dat = {{(WB_DAT_W-8){1'b0}}, s_q.rdata};

  // decoded settings per logical device
  logic [NUM_LD-1:0] dev_on;
  assign dev_on[LD_KBD[1:0]]   = s_q.ld[LD_KBD[1:0]].act[ACT_BIT] & kbd_power_enable_in;
  assign dev_on[LD_MOUSE[1:0]] = s_q.ld[LD_MOUSE[1:0]].act[ACT_BIT] & kbd_power_enable_in;
  assign dev_on[LD_CLOCK[1:0]] = s_q.ld[LD_CLOCK[1:0]].act[ACT_BIT] & clock_power_enable_in;

  genvar g;
  generate
    for (g = 0; g < NUM_LD; g++) begin : g_cfg
      assign ld_cfg_out[g].active       = dev_on[g];
      assign ld_cfg_out[g].base         = {s_q.ld[g].base_hi, s_q.ld[g].base_lo};
      assign ld_cfg_out[g].cmd_base     = {s_q.ld[g].cmd_hi, s_q.ld[g].cmd_lo};
      assign ld_cfg_out[g].irq_level    = s_q.ld[g].isel[3:0];
      assign ld_cfg_out[g].irq_is_level = s_q.ld[g].itype[ITYPE_LEVEL_BIT];
      assign ld_cfg_out[g].irq_high     = s_q.ld[g].itype[ITYPE_HIGH_BIT];
      assign ld_cfg_out[g].range_chk    = s_q.ld[g].range_chk[1:0];
    end
    // irq pin drivers for keyboard and mouse
    for (g = 0; g < 2; g++) begin : g_irq
      logic fire;
      assign fire = irq_req_in[g] & dev_on[g];
      assign irq_pin_out[g]    = s_q.ld[g].itype[ITYPE_HIGH_BIT] & fire;
      assign irq_pin_oe_out[g] = s_q.ld[g].itype[ITYPE_HIGH_BIT] | fire;
    end
  endgenerate

  // pointing device commands depend on the controller, not the mouse activate bit
  assign aux_cmd_accept_out = aux_cmd_req_in & kbd_power_enable_in;

  // clock power control follows its enable only
  assign clock_power_control_out = clock_power_enable_in;

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  chk_soft_reset_defaults: assert property (soft_rst |=> s_q.ld[0].base_lo == BASE_LO_RST[0] &&
      s_q.ld[1].isel == ISEL_RST[1] && s_q.ld[2].itype == ITYPE_RST[2])
    else $error("soft reset did not restore defaults");
  chk_vendor_keep: assert property (soft_rst |=> s_q.ld[0].vendor == $past(s_q.ld[0].vendor) &&
      s_q.chip_cfg == $past(s_q.chip_cfg))
    else $error("vendor bytes changed on soft reset");
  chk_csn_ldn_hard: assert property (!s_q.init_done |-> s_q.card_select_number == BYTE_ZERO && s_q.ldn == BYTE_ZERO)
    else $error("card number not zero after hard reset");
  chk_kbd_data_bit: assert property (s_q.init_done |-> s_q.ld[0].base_lo[2] == 1'b0)
    else $error("keyboard data base bit 2 not zero");
  chk_kbd_cmd_bit: assert property (s_q.init_done |-> s_q.ld[0].cmd_lo[2] == 1'b1)
    else $error("keyboard command base bit 2 not one");
  chk_itype_fixed: assert property (s_q.init_done |-> s_q.ld[0].itype[7:2] == 6'h00 &&
      s_q.ld[1].itype[7:2] == 6'h00 && (s_q.ld[2].itype & ~ITYPE_WMASK[2]) == BYTE_ZERO)
    else $error("read-only interrupt type bits changed");
  chk_strap_act: assert property (!s_q.init_done ##1 1'b1 |-> s_q.ld[0].act == {7'h00, $past(strap_config_bit_in)})
    else $error("keyboard activate does not follow strap");
  chk_mouse_irq_gate: assert property (!s_q.ld[1].act[ACT_BIT] |-> !(irq_pin_oe_out[1] &&
      irq_pin_out[1] == s_q.ld[1].itype[ITYPE_HIGH_BIT]))
    else $error("mouse irq asserted while inactive");
  chk_dma_read: assert property (req && !s_q.ack && !wb_req_in.we && ldn_ok &&
      (idx == IDX_DMA0 || idx == IDX_DMA1) |=> wb_rsp_out.ack && wb_rsp_out.dat[7:0] == DMA_NONE)
    else $error("dma select did not read 04h");
  chk_clock_power: assert property (!s_q.ld[2].act[ACT_BIT] |-> clock_power_control_out == clock_power_enable_in)
    else $error("clock power control stopped by activate");
  chk_clock_base_bit: assert property (s_q.init_done |-> s_q.ld[2].base_lo[0] == 1'b0)
    else $error("clock base bit 0 not zero");
  chk_ack_single: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack held longer than one cycle");

  cov_soft_reset: cover property (soft_rst);
  cov_mouse_write: cover property (commit_wr && s_q.ldn == LD_MOUSE && idx == IDX_ISEL);
  cov_mouse_irq: cover property (irq_req_in[1] && dev_on[1]);

endmodule : pnp_config_register_bank

// ===== pnp_cfg_pkg.sv
package pnp_cfg_pkg;

  // bus geometry
  localparam int          NUM_LD    = 3;
  localparam int          WB_ADR_W  = 10;
  localparam int          WB_DAT_W  = 32;
  localparam int          IDX_LSB   = 2;
  localparam int          SEL_LOW   = 0;

  // card level register indices
  localparam logic [7:0]  IDX_RD_PORT  = 8'h00;
  localparam logic [7:0]  IDX_ISOL     = 8'h01;
  localparam logic [7:0]  IDX_CTRL     = 8'h02;
  localparam logic [7:0]  IDX_WAKE     = 8'h03;
  localparam logic [7:0]  IDX_RES_DATA = 8'h04;
  localparam logic [7:0]  IDX_STATUS   = 8'h05;
  localparam logic [7:0]  IDX_CSN      = 8'h06;
  localparam logic [7:0]  IDX_LDN      = 8'h07;
  localparam logic [7:0]  IDX_CHIP_ID  = 8'h20;
  localparam logic [7:0]  IDX_CFG_ONE  = 8'h21;
  localparam logic [7:0]  IDX_CFG_TWO  = 8'h22;
  localparam logic [7:0]  IDX_CS_INDEX = 8'h23;
  localparam logic [7:0]  IDX_CS_DATA  = 8'h24;
  localparam logic [7:0]  IDX_CHIP_REV = 8'h27;

  // logical device register indices
  localparam logic [7:0]  IDX_ACT      = 8'h30;
  localparam logic [7:0]  IDX_RANGE    = 8'h31;
  localparam logic [7:0]  IDX_BASE_HI  = 8'h60;
  localparam logic [7:0]  IDX_BASE_LO  = 8'h61;
  localparam logic [7:0]  IDX_CMD_HI   = 8'h62;
  localparam logic [7:0]  IDX_CMD_LO   = 8'h63;
  localparam logic [7:0]  IDX_ISEL     = 8'h70;
  localparam logic [7:0]  IDX_ITYPE    = 8'h71;
  localparam logic [7:0]  IDX_DMA0     = 8'h74;
  localparam logic [7:0]  IDX_DMA1     = 8'h75;
  localparam logic [7:0]  IDX_VENDOR   = 8'hF0;

  // logical device numbers
  localparam logic [7:0]  LD_KBD       = 8'h00;
  localparam logic [7:0]  LD_MOUSE     = 8'h01;
  localparam logic [7:0]  LD_CLOCK     = 8'h02;
  localparam logic [7:0]  LD_COUNT     = 8'h03;

  // field positions and masks
  localparam int          CTRL_SOFT_RST_BIT = 0;
  localparam int          ACT_BIT           = 0;
  localparam int          ITYPE_LEVEL_BIT   = 0;
  localparam int          ITYPE_HIGH_BIT    = 1;
  localparam logic [7:0]  ACT_WMASK         = 8'h01;
  localparam logic [7:0]  RANGE_WMASK       = 8'h03;
  localparam logic [7:0]  BYTE_ZERO         = 8'h00;
  localparam logic [7:0]  DMA_NONE          = 8'h04;
  localparam logic [7:0]  VENDOR_RST        = 8'h00;

  // per device reset values and writable masks, index = logical device
  localparam logic [NUM_LD-1:0][7:0] BASE_LO_RST   = {8'h70, 8'h00, 8'h60};
  localparam logic [NUM_LD-1:0][7:0] BASE_LO_WMASK = {8'hFE, 8'h00, 8'hFB};
  localparam logic [7:0]             CMD_LO_RST    = 8'h64;
  localparam logic [7:0]             CMD_LO_WMASK  = 8'hFB;
  localparam logic [NUM_LD-1:0][7:0] ISEL_RST      = {8'h08, 8'h0C, 8'h01};
  localparam logic [NUM_LD-1:0][7:0] ITYPE_RST     = {8'h00, 8'h02, 8'h02};
  localparam logic [NUM_LD-1:0][7:0] ITYPE_WMASK   = {8'h02, 8'h03, 8'h03};

  // one logical device's register set
  typedef struct packed {
    logic [7:0] act;
    logic [7:0] range_chk;
    logic [7:0] base_hi;
    logic [7:0] base_lo;
    logic [7:0] cmd_hi;
    logic [7:0] cmd_lo;
    logic [7:0] isel;
    logic [7:0] itype;
    logic [7:0] vendor;
  } ld_regs_s;

  // classic wishbone request and answer
  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [WB_ADR_W-1:0] adr;
    logic [3:0]          sel;
    logic [WB_DAT_W-1:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic                ack;
    logic [WB_DAT_W-1:0] dat;
  } wb_rsp_s;

  // decoded settings handed to each logical device
  typedef struct packed {
    logic        active;
    logic [15:0] base;
    logic [15:0] cmd_base;
    logic [3:0]  irq_level;
    logic        irq_is_level;
    logic        irq_high;
    logic [1:0]  range_chk;
  } ld_cfg_s;

endpackage : pnp_cfg_pkg

// ===== pnp_host_model.sv
module pnp_host_model
  import pnp_cfg_pkg::*;
(
  // clock
  input  wire logic    sys_clk_in,
  // wishbone master side
  output wb_req_s      wb_req_out,
  input  wire wb_rsp_s wb_rsp_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle from time zero
  initial begin
    wb_req_out = '0;
  end

  // one classic cycle: request held until the edge that samples ack high
  task automatic access(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
    int n;
    rd = 8'h00;
    ok = 1'b0;
    @(posedge sys_clk_in);
    wb_req_out <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'h0}, sel: 4'h1, dat: {24'h000000, wd}};
    // ack and read data are taken at the rising edge that samples ack high
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge sys_clk_in);
      if (wb_rsp_in.ack === 1'b1) begin
        ok = 1'b1;
        rd = wb_rsp_in.dat[7:0];
      end
    end
    // released at that same edge; address and data lines show the inverse of their last value
    wb_req_out.cyc <= 1'b0;
    wb_req_out.stb <= 1'b0;
    wb_req_out.adr <= ~wb_req_out.adr;
    wb_req_out.dat <= ~wb_req_out.dat;
  endtask : access

endmodule : pnp_host_model

// ===== tb.sv
module tb
  import pnp_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  sys_clk;
  logic                  nrst;
  wb_req_s               wb_req;
  wb_rsp_s               wb_rsp;
  logic                  strap;
  logic                  kbd_pe;
  logic                  clk_pe;
  logic [1:0]            irq_req;
  logic [1:0]            irq_pin;
  logic [1:0]            irq_oe;
  logic                  aux_req;
  logic                  aux_acc;
  ld_cfg_s [NUM_LD-1:0]  ld_cfg;
  logic                  pwr_ctl;
  int                    miscompares = 0;
  int                    compares = 0;
  // register indices and their reset values per device (keyboard, mouse, clock)
  logic [7:0]            idx_t [7] = '{8'h30, 8'h61, 8'h63, 8'h70, 8'h71, 8'h74, 8'h75};
  logic [7:0]            rst_t [3][7] = '{'{8'h01, 8'h60, 8'h64, 8'h01, 8'h02, 8'h04, 8'h04},
                                          '{8'h00, 8'h00, 8'h00, 8'h0C, 8'h02, 8'h04, 8'h04},
                                          '{8'h01, 8'h70, 8'h00, 8'h08, 8'h00, 8'h04, 8'h04}};
  // device, index, written value, value read back
  logic [7:0]            ro_t [8][4] = '{'{8'h00, 8'h61, 8'hFF, 8'hFB}, '{8'h00, 8'h63, 8'h00, 8'h04},
                                         '{8'h00, 8'h71, 8'hFF, 8'h03}, '{8'h00, 8'h74, 8'h00, 8'h04},
                                         '{8'h01, 8'h71, 8'hFF, 8'h03}, '{8'h01, 8'h75, 8'h00, 8'h04},
                                         '{8'h02, 8'h61, 8'hFF, 8'hFE}, '{8'h02, 8'h71, 8'hFF, 8'h02}};

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  pnp_config_register_bank dut_u (
    .sys_clk_in(sys_clk), .nrst_in(nrst), .wb_req_in(wb_req), .wb_rsp_out(wb_rsp),
    .strap_config_bit_in(strap), .kbd_power_enable_in(kbd_pe), .clock_power_enable_in(clk_pe),
    .irq_req_in(irq_req), .irq_pin_out(irq_pin), .irq_pin_oe_out(irq_oe),
    .aux_cmd_req_in(aux_req), .aux_cmd_accept_out(aux_acc),
    .ld_cfg_out(ld_cfg), .clock_power_control_out(pwr_ctl));

  pnp_host_model host_u (.sys_clk_in(sys_clk), .wb_req_out(wb_req), .wb_rsp_in(wb_rsp));

  // verdict and end of run
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // compare one value against its expectation
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // bus access; a missing ack ends the run
  task automatic acc(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    logic ok;
    host_u.access(we, idx, wd, rd, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR bus ack expected 1 seen 0");
      report_and_stop();
    end
  endtask : acc

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    acc(1'b1, idx, wd, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    acc(1'b0, idx, 8'h00, d);
    check(name, d, exp);
  endtask : rd_chk

  // reset values of card and device registers
  task automatic t_hard_reset;
    rd_chk("csn", IDX_CSN, 8'h00);
    rd_chk("ldn", IDX_LDN, 8'h00);
    wr(IDX_CSN, 8'hA7);
    rd_chk("csn", IDX_CSN, 8'hA7);
    for (int ld = 0; ld < 3; ld++) begin
      wr(IDX_LDN, 8'(ld));
      rd_chk("ldn", IDX_LDN, 8'(ld));
      for (int i = 0; i < 7; i++) begin
        rd_chk($sformatf("ld%0d_%h", ld, idx_t[i]), idx_t[i], rst_t[ld][i]);
      end
    end
    // decoded settings carry the same reset values
    @(negedge sys_clk);
    check("kbd_base", ld_cfg[0].base[7:0], 8'h60);
    check("kbd_cmd_base", ld_cfg[0].cmd_base[7:0], 8'h64);
    check("kbd_irq_level", {4'h0, ld_cfg[0].irq_level}, 8'h01);
    check("mouse_irq_level", {4'h0, ld_cfg[1].irq_level}, 8'h0C);
    check("clock_base", ld_cfg[2].base[7:0], 8'h70);
    check("clock_irq_level", {4'h0, ld_cfg[2].irq_level}, 8'h08);
  endtask : t_hard_reset

  // fixed bits survive writes of the opposite value
  task automatic t_read_only;
    for (int i = 0; i < 8; i++) begin
      wr(IDX_LDN, ro_t[i][0]);
      wr(ro_t[i][1], ro_t[i][2]);
      rd_chk($sformatf("ro_ld%0d_%h", ro_t[i][0], ro_t[i][1]), ro_t[i][1], ro_t[i][3]);
    end
  endtask : t_read_only

  // soft reset restores defaults but keeps vendor registers
  task automatic t_soft_reset;
    wr(IDX_LDN, LD_KBD);
    wr(IDX_VENDOR, 8'h3C);
    wr(IDX_ISEL, 8'h05);
    wr(IDX_BASE_LO, 8'h80);
    wr(IDX_CFG_ONE, 8'h5A);
    wr(IDX_CS_DATA, 8'hC3);
    @(posedge sys_clk);
    strap <= 1'b0;
    wr(IDX_CTRL, 8'h01);
    rd_chk("cfg_one", IDX_CFG_ONE, 8'h5A);
    rd_chk("cs_data", IDX_CS_DATA, 8'hC3);
    rd_chk("kbd_vendor", IDX_VENDOR, 8'h3C);
    rd_chk("kbd_isel", IDX_ISEL, 8'h01);
    rd_chk("kbd_base_lo", IDX_BASE_LO, 8'h60);
    rd_chk("kbd_act", IDX_ACT, 8'h00);
    wr(IDX_LDN, LD_CLOCK);
    rd_chk("clock_act", IDX_ACT, 8'h00);
    rd_chk("clock_itype", IDX_ITYPE, 8'h00);
    rd_chk("unmapped", 8'h50, 8'h00);
  endtask : t_soft_reset

  // interrupt pins, polarity and activation gating
  task automatic t_irq_pins;
    @(posedge sys_clk);
    irq_req <= 2'h3;
    aux_req <= 1'b1;
    wr(IDX_LDN, LD_MOUSE);
    @(negedge sys_clk);
    check("mouse_pin_idle", {6'h00, irq_oe[1], irq_pin[1]}, 8'h02);
    check("aux_accept", {7'h00, aux_acc}, 8'h01);
    wr(IDX_ACT, 8'h01);
    @(negedge sys_clk);
    check("mouse_pin_high", {6'h00, irq_oe[1], irq_pin[1]}, 8'h03);
    wr(IDX_ITYPE, 8'h00);
    @(negedge sys_clk);
    check("mouse_pin_low", {6'h00, irq_oe[1], irq_pin[1]}, 8'h02);
    wr(IDX_ACT, 8'h00);
    @(negedge sys_clk);
    check("mouse_pin_off", {6'h00, irq_oe[1], irq_pin[1]}, 8'h00);
    check("aux_accept_off", {7'h00, aux_acc}, 8'h01);
    wr(IDX_LDN, LD_KBD);
    wr(IDX_ACT, 8'h01);
    @(posedge sys_clk);
    kbd_pe <= 1'b0;
    @(negedge sys_clk);
    check("kbd_gated", {7'h00, ld_cfg[0].active}, 8'h00);
    @(posedge sys_clk);
    kbd_pe <= 1'b1;
    @(negedge sys_clk);
    check("kbd_active", {7'h00, ld_cfg[0].active}, 8'h01);
    check("kbd_pin_high", {6'h00, irq_oe[0], irq_pin[0]}, 8'h03);
    wr(IDX_ITYPE, 8'h01);
    @(negedge sys_clk);
    check("kbd_type", {6'h00, ld_cfg[0].irq_high, ld_cfg[0].irq_is_level}, 8'h01);
    check("kbd_pin_low", {6'h00, irq_oe[0], irq_pin[0]}, 8'h02);
  endtask : t_irq_pins

  // power control keeps running while the clock device activation bit is cleared
  task automatic t_clock_power;
    wr(IDX_LDN, LD_CLOCK);
    wr(IDX_ACT, 8'h00);
    @(negedge sys_clk);
    check("clock_inactive", {7'h00, ld_cfg[2].active}, 8'h00);
    check("clock_power_on", {7'h00, pwr_ctl}, 8'h01);
  endtask : t_clock_power

  // reset, scenarios, verdict
  initial begin
    nrst = 1'b0;
    strap = 1'b1;
    kbd_pe = 1'b1;
    clk_pe = 1'b1;
    irq_req = 2'h0;
    aux_req = 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_hard_reset();
    t_read_only();
    t_soft_reset();
    t_irq_pins();
    t_clock_power();
    report_and_stop();
  end

endmodule : tb
